//--- pad_mux_cfg.svh
// Constants for the serial port pad routing: mode codes, pad slots and port numbers.
`ifndef PAD_MUX_CFG_SVH
`define PAD_MUX_CFG_SVH

// ****************************************************************
// Mode field codes
// ****************************************************************
`define MODE_SERIAL 2'h0
`define MODE_CARD 2'h2
`define MODE_RESET 2'h0

// ****************************************************************
// Pad slots within one six-pad port group
// ****************************************************************
`define PAD_COUNT 6
`define PAD_RX_CLOCK 0
`define PAD_RX_DATA 1
`define PAD_RX_FRAME_SYNC 2
`define PAD_TX_DATA 3
`define PAD_TX_CLOCK 4
`define PAD_TX_FRAME_SYNC 5

// ****************************************************************
// Port numbers
// ****************************************************************
`define PORT_COUNT 3
`define PORT_FIXED 0

`endif

//--- pad_mux_pkg.sv
// Types shared by the serial port pad routing modules.
package pad_mux_pkg;
  typedef logic [5:0] pad_vec_t;
  typedef logic [1:0] mode_t;
endpackage

//--- pad_route_if.sv
// Signals passed between the pad group top and one pad group router.
interface pad_route_if;
  import pad_mux_pkg::*;
  logic card_mode;
  pad_vec_t serial_out;
  pad_vec_t serial_oe;
  pad_vec_t card_out;
  pad_vec_t card_oe;
  pad_vec_t next_out;
  pad_vec_t next_oe;
  modport router (
    input card_mode,
    input serial_out,
    input serial_oe,
    input card_out,
    input card_oe,
    output next_out,
    output next_oe
  );
  modport top (
    output card_mode,
    output serial_out,
    output serial_oe,
    output card_out,
    output card_oe,
    input next_out,
    input next_oe
  );
endinterface

//--- pad_group_router.sv
// Selects serial port or card controller drive for one six-pad group.
module pad_group_router
  import pad_mux_pkg::*;
(
  pad_route_if.router rt
);

  // Card routing keeps pad order command, data1, data2, clock, data0, data3.
  always_comb begin
    if (rt.card_mode) begin
      rt.next_out = rt.card_out;
      rt.next_oe = rt.card_oe;
    end else begin
      rt.next_out = rt.serial_out;
      rt.next_oe = rt.serial_oe;
    end
  end

endmodule // pad_group_router

//--- serial_port_pad_mux.sv
// Pad routing and direction control for three serial port pad groups.
`include "pad_mux_cfg.svh"
module serial_port_pad_mux
  import pad_mux_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic outputs_off_n,
  input wire mode_t port1_mode,
  input wire mode_t port2_mode,
  input wire pad_vec_t port0_pad_in,
  output pad_vec_t port0_pad_out,
  output pad_vec_t port0_pad_oe,
  input wire pad_vec_t port0_serial_out,
  input wire pad_vec_t port0_serial_drive,
  output logic port0_rx_start,
  output logic port0_tx_start,
  input wire pad_vec_t port1_pad_in,
  output pad_vec_t port1_pad_out,
  output pad_vec_t port1_pad_oe,
  input wire pad_vec_t port1_serial_out,
  input wire pad_vec_t port1_serial_drive,
  input wire pad_vec_t card1_out,
  input wire pad_vec_t card1_drive,
  output logic port1_rx_start,
  output logic port1_tx_start,
  input wire pad_vec_t port2_pad_in,
  output pad_vec_t port2_pad_out,
  output pad_vec_t port2_pad_oe,
  input wire pad_vec_t port2_serial_out,
  input wire pad_vec_t port2_serial_drive,
  input wire pad_vec_t card2_out,
  input wire pad_vec_t card2_drive,
  output logic port2_rx_start,
  output logic port2_tx_start
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // A frame sync pulse is recognised on its leading edge.
  function automatic logic leading_edge(input logic prev, input logic cur);
    leading_edge = cur & ~prev;
  endfunction

  // Serial direction: receive data and receive frame sync are input only,
  // transmit data drives only while the port says a transmission runs.
  function automatic pad_vec_t serial_dir(input pad_vec_t drive);
    serial_dir = drive;
    serial_dir[`PAD_RX_DATA] = 1'b0;
    serial_dir[`PAD_RX_FRAME_SYNC] = 1'b0;
  endfunction

  // ****************************************************************
  // Mode capture
  // ****************************************************************
  mode_t mode [`PORT_COUNT];
  mode_t next_mode [`PORT_COUNT];
  pad_vec_t pad_in [`PORT_COUNT];
  pad_vec_t ser_out [`PORT_COUNT];
  pad_vec_t ser_drive [`PORT_COUNT];
  pad_vec_t card_out [`PORT_COUNT];
  pad_vec_t card_drive [`PORT_COUNT];

  // Gather the per-port pins so that each group is handled by one loop.
  always_comb begin
    pad_in[0] = port0_pad_in;
    pad_in[1] = port1_pad_in;
    pad_in[2] = port2_pad_in;
    ser_out[0] = port0_serial_out;
    ser_out[1] = port1_serial_out;
    ser_out[2] = port2_serial_out;
    ser_drive[0] = port0_serial_drive;
    ser_drive[1] = port1_serial_drive;
    ser_drive[2] = port2_serial_drive;
    card_out[0] = '0;
    card_out[1] = card1_out;
    card_out[2] = card2_out;
    card_drive[0] = '0;
    card_drive[1] = card1_drive;
    card_drive[2] = card2_drive;
  end

  // Port zero has no card function, so its mode stays serial.
  always_comb begin
    next_mode[0] = `MODE_SERIAL;
    next_mode[1] = port1_mode;
    next_mode[2] = port2_mode;
  end

  // Reset returns all three groups to serial routing.
  always_ff @(posedge mclk) begin
    for (int p = 0; p < `PORT_COUNT; p++) begin
      if (reset) begin
        mode[p] <= `MODE_RESET;
      end else begin
        mode[p] <= next_mode[p];
      end
    end
  end

  // ****************************************************************
  // Routing and pad registers
  // ****************************************************************
  pad_vec_t pad_out [`PORT_COUNT];
  pad_vec_t pad_oe [`PORT_COUNT];
  pad_vec_t next_out [`PORT_COUNT];
  pad_vec_t next_oe [`PORT_COUNT];
  logic fs_prev_rx [`PORT_COUNT];
  logic fs_prev_tx [`PORT_COUNT];
  logic rx_start [`PORT_COUNT];
  logic tx_start [`PORT_COUNT];
  logic next_rx_start [`PORT_COUNT];
  logic next_tx_start [`PORT_COUNT];

  for (genvar p = 0; p < `PORT_COUNT; p++) begin : g_port
    pad_route_if rt ();
    pad_vec_t card_dir;

    // Card clock pad is always driven; the rest follow the card.
    always_comb begin
      card_dir = card_drive[p];
      card_dir[`PAD_TX_DATA] = 1'b1;
    end

    // Only code 10 selects the card; 01 and 11 stay serial.
    assign rt.card_mode = (mode[p] == `MODE_CARD);
    assign rt.serial_out = ser_out[p];
    // Serial transmit data drives only while transmitting.
    assign rt.serial_oe = serial_dir(ser_drive[p]);
    assign rt.card_out = card_out[p];
    assign rt.card_oe = card_dir;

    // Mode selects which function owns the pad group.
    pad_group_router u_router (
      .rt(rt.router)
    );

    // The global output disable overrides every driver.
    always_comb begin
      next_out[p] = rt.next_out;
      next_oe[p] = outputs_off_n ? rt.next_oe : '0;
    end

    // Frame sync leading edges are reported only in serial routing.
    always_comb begin
      next_rx_start[p] = ~rt.card_mode &
        leading_edge(fs_prev_rx[p], pad_in[p][`PAD_RX_FRAME_SYNC]);
      next_tx_start[p] = ~rt.card_mode &
        leading_edge(fs_prev_tx[p], pad_in[p][`PAD_TX_FRAME_SYNC]);
    end

    // Reset releases every pad, so all pads become inputs or hi-Z.
    always_ff @(posedge mclk) begin
      if (reset) begin
        pad_out[p] <= '0;
        pad_oe[p] <= '0;
        fs_prev_rx[p] <= 1'b0;
        fs_prev_tx[p] <= 1'b0;
        rx_start[p] <= 1'b0;
        tx_start[p] <= 1'b0;
      end else begin
        pad_out[p] <= next_out[p];
        pad_oe[p] <= next_oe[p];
        fs_prev_rx[p] <= pad_in[p][`PAD_RX_FRAME_SYNC];
        fs_prev_tx[p] <= pad_in[p][`PAD_TX_FRAME_SYNC];
        rx_start[p] <= next_rx_start[p];
        tx_start[p] <= next_tx_start[p];
      end
    end
  end

  // Every output below is a flip-flop.
  assign port0_pad_out = pad_out[0];
  assign port0_pad_oe = pad_oe[0];
  assign port1_pad_out = pad_out[1];
  assign port1_pad_oe = pad_oe[1];
  assign port2_pad_out = pad_out[2];
  assign port2_pad_oe = pad_oe[2];
  assign port0_rx_start = rx_start[0];
  assign port0_tx_start = tx_start[0];
  assign port1_rx_start = rx_start[1];
  assign port1_tx_start = tx_start[1];
  assign port2_rx_start = rx_start[2];
  assign port2_tx_start = tx_start[2];

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Serial routing copies serial output.
  // The first edge after reset still shows the cleared pads, so it is skipped.
  a_port1_serial_route: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && $past(mode[1]) == `MODE_SERIAL) |->
      (port1_pad_out == $past(port1_serial_out)))
    else $error("port one serial routing wrong");

  a_port1_card_route: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && $past(mode[1]) == `MODE_CARD) |-> (port1_pad_out == $past(card1_out)))
    else $error("port one card routing wrong");

  a_port2_serial_route: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && $past(mode[2]) == `MODE_SERIAL) |->
      (port2_pad_out == $past(port2_serial_out)))
    else $error("port two serial routing wrong");

  a_port2_card_route: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && $past(mode[2]) == `MODE_CARD && $past(outputs_off_n)) |->
      (port2_pad_out == $past(card2_out) && port2_pad_oe[0] == $past(card2_drive[0])))
    else $error("port two card routing wrong");

  // Card clock pad driven in card mode.
  a_card_clock_out: assert property (@(posedge mclk) disable iff (reset)
    ($past(mode[1]) == `MODE_CARD && $past(outputs_off_n)) |-> port1_pad_oe[3])
    else $error("card clock pad not driven");

  // Idle or disabled transmit data stays hi-Z.
  // Each port is judged by its own transmit request, never by another port's.
  a_tx_data_idle: assert property (@(posedge mclk) disable iff (reset)
    ((!$past(outputs_off_n)) || ($past(mode[2]) != `MODE_CARD &&
      !$past(port2_serial_drive[3]))) |-> !port2_pad_oe[3])
    else $error("transmit data driven while idle or off");

  a_port0_tx_idle: assert property (@(posedge mclk) disable iff (reset)
    (!$past(outputs_off_n) || !$past(port0_serial_drive[3])) |-> !port0_pad_oe[3])
    else $error("port zero transmit data driven while idle or off");

  // First cycle after reset every pad is undriven.
  a_reset_inputs: assert property (@(posedge mclk) disable iff (reset)
    $past(reset) |-> (port0_pad_oe == '0 && port1_pad_oe == '0 && port2_pad_oe == '0))
    else $error("pad driven right after reset");

  // Receive clock, frame sync and transmit data pads hi-Z at reset.
  a_reset_tristate: assert property (@(posedge mclk) disable iff (reset)
    $past(reset) |-> !port0_pad_oe[0] && !port0_pad_oe[2] && !port1_pad_oe[3] &&
      !port2_pad_oe[3])
    else $error("reset pad not hi-Z");

  // Receive frame sync edge yields one start pulse.
  a_rx_start_pulse: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2) && $past(port1_pad_in[2]) &&
      !$past(port1_pad_in[2], 2) &&
      $past(mode[1]) != `MODE_CARD) |-> port1_rx_start ##1 !port1_rx_start || $past(port1_pad_in[2]) == 1'b0)
    else $error("receive start pulse missing");

  a_reserved_serial: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && ($past(mode[1]) == 2'h1 || $past(mode[1]) == 2'h3)) |->
      (port1_pad_out == $past(port1_serial_out)))
    else $error("reserved mode left serial routing");

endmodule // serial_port_pad_mux

//--- codec_card_model.sv
// Far-side model of a codec or card that faces one six-pad group.
module codec_card_model
  import pad_mux_pkg::*;
(
  input wire logic mclk,
  input wire logic active,
  input wire logic [3:0] gap,
  input wire pad_vec_t pad_out,
  input wire pad_vec_t pad_oe,
  output pad_vec_t pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  pad_vec_t drv = 6'h00;
  // The lines that are not frame syncs flip every cycle, so a stale value is never seen.
  // frame sync pulses
  always @(posedge mclk) begin
    #1;
    cnt = (cnt >= gap) ? 4'h0 : cnt + 4'h1;
    drv = {active && cnt == 4'h0, ~drv[4:3], active && cnt == 4'h1, ~drv[1:0]};
  end
  // The design wins on every slot that it enables.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);
endmodule // codec_card_model

//--- tb_top.sv
// Self-checking bench for the serial port pad routing, with a reference model.
module tb_top
  import pad_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic off_n = 1'b1;
  logic active = 1'b0;
  logic rnd_on = 1'b0;
  logic cmp_on = 1'b0;
  logic [3:0] gap = 4'h7;
  mode_t pmode [3] = '{default: 2'h0};
  pad_vec_t s_out [3] = '{default: 6'h00};
  pad_vec_t s_drv [3] = '{default: 6'h00};
  pad_vec_t c_out [3] = '{default: 6'h00};
  pad_vec_t c_drv [3] = '{default: 6'h00};
  pad_vec_t pin [3];
  pad_vec_t p_out [3];
  pad_vec_t p_oe [3];
  logic rx [3];
  logic tx [3];
  pad_vec_t eo [3], eoe [3], prv [3];
  logic erx [3], etx [3];
  int mq [3];
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed;

  always #10 mclk = ~mclk;

  serial_port_pad_mux serial_port_pad_mux_inst (.mclk(mclk), .reset(reset),
    .outputs_off_n(off_n), .port1_mode(pmode[1]), .port2_mode(pmode[2]),
    .port0_pad_in(pin[0]), .port0_pad_out(p_out[0]), .port0_pad_oe(p_oe[0]),
    .port0_serial_out(s_out[0]), .port0_serial_drive(s_drv[0]),
    .port0_rx_start(rx[0]), .port0_tx_start(tx[0]),
    .port1_pad_in(pin[1]), .port1_pad_out(p_out[1]), .port1_pad_oe(p_oe[1]),
    .port1_serial_out(s_out[1]), .port1_serial_drive(s_drv[1]), .card1_out(c_out[1]),
    .card1_drive(c_drv[1]), .port1_rx_start(rx[1]), .port1_tx_start(tx[1]),
    .port2_pad_in(pin[2]), .port2_pad_out(p_out[2]), .port2_pad_oe(p_oe[2]),
    .port2_serial_out(s_out[2]), .port2_serial_drive(s_drv[2]), .card2_out(c_out[2]),
    .card2_drive(c_drv[2]), .port2_rx_start(rx[2]), .port2_tx_start(tx[2]));

  for (genvar k = 0; k < 3; k++) begin : g_far
    codec_card_model codec_card_model_inst (.mclk(mclk), .active(active), .gap(gap),
      .pad_out(p_out[k]), .pad_oe(p_oe[k]), .pad_in(pin[k]));
  end

  // ****************************************************************
  // Reference model and comparison
  // ****************************************************************
  // Modes pass a register first, so pads follow a new mode one edge later.
  always @(posedge mclk) begin
    for (int k = 0; k < 3; k++) begin
      if (reset) begin
        eo[k] <= 6'h00;
        eoe[k] <= 6'h00;
        erx[k] <= 1'b0;
        etx[k] <= 1'b0;
        mq[k] <= 0;
        // Frame syncs idle low, so the edge history restarts from low.
        prv[k] <= 6'h00;
      end else begin
        eo[k] <= (mq[k] == 2) ? c_out[k] : s_out[k];
        eoe[k] <= !off_n ? 6'h00 : (mq[k] == 2) ? (c_drv[k] | 6'h08) : (s_drv[k] & 6'h39);
        erx[k] <= mq[k] != 2 && pin[k][2] && !prv[k][2];
        etx[k] <= mq[k] != 2 && pin[k][5] && !prv[k][5];
        mq[k] <= pmode[k];
        prv[k] <= pin[k];
      end
    end
  end

  task automatic check(input pad_vec_t seen, input pad_vec_t exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs have settled by the falling edge.
  always @(negedge mclk) begin
    if (cmp_on) begin
      for (int k = 0; k < 3; k++) begin
        check(p_out[k], eo[k]);
        check(p_oe[k], eoe[k]);
        check({5'h00, rx[k]}, {5'h00, erx[k]});
        check({5'h00, tx[k]}, {5'h00, etx[k]});
      end
    end
  end

  // ****************************************************************
  // Stimulus and sequence
  // ****************************************************************
  // The counter cuts a hang short.
  always @(posedge mclk) begin
    #1;
    cycles++;
    if (cycles > 3000) begin
      errors++;
      report_and_stop();
    end
  end

  // Random values are drawn in the seeded thread, so the seed governs them.
  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (rnd_on) begin
        for (int k = 0; k < 3; k++) begin
          s_out[k] = pad_vec_t'($urandom);
          s_drv[k] = pad_vec_t'($urandom);
          c_out[k] = pad_vec_t'($urandom);
          c_drv[k] = pad_vec_t'($urandom);
        end
      end
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    seed = $urandom(32'h575FCC4F);
    step(2);
    cmp_on = 1'b1;
    step(10);
    reset = 1'b0;
    rnd_on = 1'b1;
    active = 1'b1;
    $display("test reset state done");
    // Every mode code on both ports, with prompt and slow frame syncs.
    for (int m = 0; m < 4; m++) begin
      pmode[1] = mode_t'(m);
      pmode[2] = mode_t'(3 - m);
      gap = m[0] ? 4'h1 : 4'hB;
      step(25);
    end
    $display("test mode codes done");
    pmode[1] = 2'h2;
    pmode[2] = 2'h0;
    off_n = 1'b0;
    step(10);
    off_n = 1'b1;
    step(5);
    $display("test output disable done");
    // A second reset while both groups sit in card mode.
    pmode[2] = 2'h2;
    active = 1'b0;
    step(4);
    reset = 1'b1;
    step(3);
    reset = 1'b0;
    step(2);
    active = 1'b1;
    step(10);
    $display("test mid-run reset done");
    // Port one mode flips on every cycle, port two on every second, the tightest spacing allowed.
    for (int i = 0; i < 12; i++) begin
      pmode[1] = i[0] ? 2'h2 : 2'h0;
      pmode[2] = i[1] ? 2'h2 : 2'h1;
      step(1);
    end
    step(4);
    $display("test back-to-back modes done");
    report_and_stop();
  end
endmodule // tb_top
